//--- sld_map.svh
// Overview of operation
// - Reference predivider divides by its 5-bit value, 1..31; codes 0 and 1 divide by one.
// - Feedback divider divides by its 8-bit value plus one, one to 256.
// - Feedback divider power-down bit set stops it; zero, the default, runs it.
// - On sync the feedback divider restarts at its 6-bit initial phase.
// - Each phase step is half an input period; 63 gives 31.5 periods.
// - Bypass bit set shorts the internal zero resistor; board adds external one.
// - VCO output divider power-down removes the feedback divider input clock.
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH
// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define SLD_IDX_BYPASS   12'h206
`define SLD_IDX_PREDIV   12'h207
`define SLD_IDX_FBDIV    12'h208
`define SLD_IDX_FBPHASE  12'h209
`define SLD_IDX_AUX      12'h20A
`define SLD_IDX_STATUS   12'h20B
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLD_BYPASS_BIT   0
`define SLD_FBPD_BIT     6
`define SLD_PHASE_MSB    5
`define SLD_PREDIV_MSB   4
`define SLD_AUX_SYNC_BIT 0
`define SLD_AUX_VPD_BIT  1
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLD_RST_BYPASS   1'h0
`define SLD_RST_PREDIV   5'h00
`define SLD_RST_FBDIV    8'h00
`define SLD_RST_FBPD     1'h0
`define SLD_RST_PHASE    6'h00
`define SLD_RST_VPD      1'h0
`endif

//--- sld_pkg.sv
package sld_pkg;
	typedef struct packed {
		logic       zero_bypass;
		logic [4:0] prediv;
		logic [7:0] fbdiv;
		logic       fb_pd;
		logic [5:0] fb_phase;
		logic       vco_pd;
	} sld_cfg_t;

	typedef struct packed {
		logic       fb_level;
		logic       fb_pulse;
		logic       ref_pulse;
		logic       fb_delaying;
	} sld_stat_t;

	typedef enum logic [1:0] {
		SLD_BUS_IDLE = 2'b01,
		SLD_BUS_ACK  = 2'b10
	} sld_bus_st_t;
endpackage

//--- sld_top.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "sld_map.svh"
module sld_top (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [13:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ref_edge_en,
	input  wire logic        vco_half_en,
	input  wire logic        sync_in,
	output logic             ref_div_pulse,
	output logic             fb_div_pulse,
	output logic             fb_div_level,
	output logic             loop_zero_bypass,
	output logic             vco_output_divider_pd,
	output logic             feedback_divider_pd
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic idx_hit(input logic [13:0] a, input logic [11:0] idx);
		return a[13:2] == idx;
	endfunction

	function automatic logic [4:0] prediv_ratio(input logic [4:0] v);
		return (v == 5'h00) ? 5'h01 : v;
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	sld_pkg::sld_bus_st_t bus_st_reg;
	sld_pkg::sld_bus_st_t bus_st_next;
	sld_pkg::sld_cfg_t    cfg_reg;
	sld_pkg::sld_cfg_t    cfg_next;
	sld_pkg::sld_stat_t   stat;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	logic                 sw_sync;
	logic                 do_write;

	assign avs_waitrequest = (avs_read | avs_write) & (bus_st_reg != sld_pkg::SLD_BUS_ACK);
	assign avs_readdata    = rdata_reg;
	assign do_write        = avs_write & (bus_st_reg == sld_pkg::SLD_BUS_ACK);

	always_comb begin
		bus_st_next = bus_st_reg;
		rdata_next  = rdata_reg;
		cfg_next    = cfg_reg;
		sw_sync     = 1'b0;
		unique case (bus_st_reg)
			sld_pkg::SLD_BUS_IDLE: begin
				if (avs_read | avs_write) begin
					bus_st_next = sld_pkg::SLD_BUS_ACK;
					rdata_next  = 32'h0000_0000;
					if (avs_read) begin
						// Unused bits stay zero
						if (idx_hit(avs_address, `SLD_IDX_BYPASS))
							rdata_next[`SLD_BYPASS_BIT] = cfg_reg.zero_bypass;
						else if (idx_hit(avs_address, `SLD_IDX_PREDIV))
							rdata_next[`SLD_PREDIV_MSB:0] = cfg_reg.prediv;
						else if (idx_hit(avs_address, `SLD_IDX_FBDIV))
							rdata_next[7:0] = cfg_reg.fbdiv;
						else if (idx_hit(avs_address, `SLD_IDX_FBPHASE)) begin
							rdata_next[`SLD_FBPD_BIT] = cfg_reg.fb_pd;
							rdata_next[`SLD_PHASE_MSB:0] = cfg_reg.fb_phase;
						end
						else if (idx_hit(avs_address, `SLD_IDX_AUX))
							rdata_next[`SLD_AUX_VPD_BIT] = cfg_reg.vco_pd;
						else if (idx_hit(avs_address, `SLD_IDX_STATUS))
							rdata_next[3:0] = stat;
					end
				end
			end
			sld_pkg::SLD_BUS_ACK: begin
				bus_st_next = sld_pkg::SLD_BUS_IDLE;
				if (do_write) begin
					if (idx_hit(avs_address, `SLD_IDX_BYPASS))
						cfg_next.zero_bypass = avs_writedata[`SLD_BYPASS_BIT];
					else if (idx_hit(avs_address, `SLD_IDX_PREDIV))
						cfg_next.prediv = avs_writedata[`SLD_PREDIV_MSB:0];
					else if (idx_hit(avs_address, `SLD_IDX_FBDIV))
						cfg_next.fbdiv = avs_writedata[7:0];
					else if (idx_hit(avs_address, `SLD_IDX_FBPHASE)) begin
						cfg_next.fb_pd    = avs_writedata[`SLD_FBPD_BIT];
						cfg_next.fb_phase = avs_writedata[`SLD_PHASE_MSB:0];
					end
					else if (idx_hit(avs_address, `SLD_IDX_AUX)) begin
						cfg_next.vco_pd = avs_writedata[`SLD_AUX_VPD_BIT];
						sw_sync         = avs_writedata[`SLD_AUX_SYNC_BIT];
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_st_reg          <= sld_pkg::SLD_BUS_IDLE;
			rdata_reg           <= 32'h0000_0000;
			cfg_reg.zero_bypass <= `SLD_RST_BYPASS;
			cfg_reg.prediv      <= `SLD_RST_PREDIV;
			cfg_reg.fbdiv       <= `SLD_RST_FBDIV;
			cfg_reg.fb_pd       <= `SLD_RST_FBPD;
			cfg_reg.fb_phase    <= `SLD_RST_PHASE;
			cfg_reg.vco_pd      <= `SLD_RST_VPD;
		end else begin
			bus_st_reg <= bus_st_next;
			rdata_reg  <= rdata_next;
			cfg_reg    <= cfg_next;
		end
	end

	assign loop_zero_bypass      = cfg_reg.zero_bypass;
	assign vco_output_divider_pd = cfg_reg.vco_pd;
	assign feedback_divider_pd   = cfg_reg.fb_pd;

	// ----------------------------------------------------------------
	// Reference predivider
	// ----------------------------------------------------------------
	logic [4:0] ref_cnt_reg;
	logic [4:0] ref_cnt_next;
	logic       ref_pulse_reg;
	logic       ref_pulse_next;
	logic       ref_last;

	assign ref_last = (ref_cnt_reg >= prediv_ratio(cfg_reg.prediv) - 5'h01);

	always_comb begin
		ref_cnt_next   = ref_cnt_reg;
		ref_pulse_next = 1'b0;
		if (ref_edge_en) begin
			if (ref_last) begin
				ref_cnt_next   = 5'h00;
				ref_pulse_next = 1'b1;
			end else begin
				ref_cnt_next = ref_cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ref_cnt_reg   <= 5'h00;
			ref_pulse_reg <= 1'b0;
		end else begin
			ref_cnt_reg   <= ref_cnt_next;
			ref_pulse_reg <= ref_pulse_next;
		end
	end

	assign ref_div_pulse = ref_pulse_reg;

	// ----------------------------------------------------------------
	// Feedback divider, counted in half periods of its input clock
	// ----------------------------------------------------------------
	logic [8:0] fb_cnt_reg;
	logic [8:0] fb_cnt_next;
	logic [5:0] fb_dly_reg;
	logic [5:0] fb_dly_next;
	logic       fb_pulse_reg;
	logic       fb_pulse_next;
	logic       fb_level_reg;
	logic       fb_level_next;
	logic       fb_step;
	logic       fb_sync;
	logic [8:0] fb_top;

	assign fb_step = vco_half_en & ~cfg_reg.vco_pd;
	assign fb_sync = sync_in | sw_sync;
	assign fb_top  = {cfg_reg.fbdiv, 1'b1};

	always_comb begin
		fb_cnt_next   = fb_cnt_reg;
		fb_dly_next   = fb_dly_reg;
		fb_pulse_next = 1'b0;
		fb_level_next = fb_level_reg;
		if (cfg_reg.fb_pd) begin
			fb_cnt_next   = 9'h000;
			fb_dly_next   = 6'h00;
			fb_level_next = 1'b0;
		end else if (fb_sync) begin
			fb_cnt_next   = 9'h000;
			fb_dly_next   = cfg_reg.fb_phase;
			fb_level_next = 1'b0;
		end else if (fb_step) begin
			if (fb_dly_reg != 6'h00) begin
				fb_dly_next = fb_dly_reg - 6'h01;
			end else begin
				fb_level_next = (fb_cnt_reg <= {1'b0, cfg_reg.fbdiv});
				if (fb_cnt_reg >= fb_top) begin
					fb_cnt_next   = 9'h000;
					fb_pulse_next = 1'b1;
				end else begin
					fb_cnt_next = fb_cnt_reg + 9'h001;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fb_cnt_reg   <= 9'h000;
			fb_dly_reg   <= 6'h00;
			fb_pulse_reg <= 1'b0;
			fb_level_reg <= 1'b0;
		end else begin
			fb_cnt_reg   <= fb_cnt_next;
			fb_dly_reg   <= fb_dly_next;
			fb_pulse_reg <= fb_pulse_next;
			fb_level_reg <= fb_level_next;
		end
	end

	assign fb_div_pulse     = fb_pulse_reg;
	assign fb_div_level     = fb_level_reg;
	assign stat = '{
		fb_level:    fb_level_reg,
		fb_pulse:    fb_pulse_reg,
		ref_pulse:   ref_pulse_reg,
		fb_delaying: (fb_dly_reg != 6'h00)
	};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_PREDIV_UNITY: assert property (
		(ref_edge_en && cfg_reg.prediv <= 5'h01) |=> ref_div_pulse)
		else $error("predivider code 0 or 1 did not divide by one");
	AST_PREDIV_RANGE: assert property (
		ref_div_pulse |-> ref_cnt_reg == 5'h00)
		else $error("predivider pulse without counter restart");
	AST_FB_BOUND: assert property (
		!$past(fb_sync) && !$past(cfg_reg.fb_pd) && $past(fb_step) && $past(fb_dly_reg) == 6'h00
		&& $past(fb_cnt_reg) == {$past(cfg_reg.fbdiv), 1'b1} |-> fb_div_pulse && fb_cnt_reg == 9'h000)
		else $error("feedback divider did not wrap at its programmed count");
	AST_FB_PD: assert property (
		cfg_reg.fb_pd |=> !fb_div_level && !fb_div_pulse && fb_cnt_reg == 9'h000)
		else $error("feedback divider ran while powered down");
	AST_SYNC_LOAD: assert property (
		(fb_sync && !cfg_reg.fb_pd) |=> fb_dly_reg == $past(cfg_reg.fb_phase) && fb_cnt_reg == 9'h000)
		else $error("sync did not load the initial phase");
	AST_PHASE_STEP: assert property (
		(fb_step && !fb_sync && !cfg_reg.fb_pd && fb_dly_reg != 6'h00)
		|=> fb_dly_reg == $past(fb_dly_reg) - 6'h01 && !fb_div_pulse)
		else $error("phase delay did not count one half period");
	AST_BYPASS_WR: assert property (
		(do_write && idx_hit(avs_address, `SLD_IDX_BYPASS))
		|=> loop_zero_bypass == $past(avs_writedata[`SLD_BYPASS_BIT]))
		else $error("bypass bit not written");
	AST_VCO_PD: assert property (
		(cfg_reg.vco_pd && !fb_sync && !cfg_reg.fb_pd) |=> $stable(fb_cnt_reg) && !fb_div_pulse)
		else $error("feedback divider advanced with its clock powered down");
	AST_RSVD_READ: assert property (
		(bus_st_reg == sld_pkg::SLD_BUS_ACK && avs_read && idx_hit(avs_address, `SLD_IDX_PREDIV))
		|-> avs_readdata[31:5] == 27'h000_0000 && !avs_waitrequest)
		else $error("reserved predivider bits read nonzero");
	AST_PREDIV_COUNT: assert property (
		(ref_edge_en && !ref_last) |=> !ref_div_pulse && ref_cnt_reg == $past(ref_cnt_reg) + 5'h01)
		else $error("predivider counter did not advance by one");
	AST_REF_HOLD: assert property (
		!ref_edge_en |=> $stable(ref_cnt_reg) && !ref_div_pulse)
		else $error("predivider moved without an input edge");
	AST_PREDIV_WR: assert property (
		(do_write && idx_hit(avs_address, `SLD_IDX_PREDIV))
		|=> cfg_reg.prediv == $past(avs_writedata[`SLD_PREDIV_MSB:0]))
		else $error("predivider code not written");
	AST_FBDIV_WR: assert property (
		(do_write && idx_hit(avs_address, `SLD_IDX_FBDIV))
		|=> cfg_reg.fbdiv == $past(avs_writedata[7:0]))
		else $error("feedback divider value not written");
	AST_FB_HIGH: assert property (
		(fb_step && !fb_sync && !cfg_reg.fb_pd && fb_dly_reg == 6'h00)
		|=> fb_div_level == ($past(fb_cnt_reg) <= {1'b0, $past(cfg_reg.fbdiv)}))
		else $error("feedback output level wrong for its half step");
	AST_FB_HOLD: assert property (
		(!fb_step && !fb_sync && !cfg_reg.fb_pd)
		|=> $stable(fb_cnt_reg) && $stable(fb_dly_reg) && !fb_div_pulse)
		else $error("feedback divider moved without an input step");
	AST_DELAY_QUIET: assert property (
		stat.fb_delaying |-> !fb_div_level && !fb_div_pulse)
		else $error("feedback output active during the initial phase delay");
	AST_SYNC_PD: assert property (
		(cfg_reg.fb_pd && fb_sync) |=> fb_dly_reg == 6'h00 && !fb_div_level)
		else $error("sync acted on a powered down feedback divider");
	AST_RSVD_PHASE: assert property (
		(bus_st_reg == sld_pkg::SLD_BUS_ACK && avs_read
		&& idx_hit(avs_address, `SLD_IDX_FBPHASE))
		|-> avs_readdata[31:7] == 25'h000_0000)
		else $error("reserved phase register bits read nonzero");
	AST_RSVD_BYPASS: assert property (
		(bus_st_reg == sld_pkg::SLD_BUS_ACK && avs_read
		&& idx_hit(avs_address, `SLD_IDX_BYPASS))
		|-> avs_readdata[31:1] == 31'h0000_0000)
		else $error("reserved bypass register bits read nonzero");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	COV_SYNC_PHASE: cover property (fb_sync && cfg_reg.fb_phase == 6'h3F ##1 stat.fb_delaying);
	COV_FB_WRAP: cover property (fb_div_pulse && cfg_reg.fbdiv == 8'hFF);
	COV_PREDIV: cover property (ref_div_pulse && cfg_reg.prediv == 5'h1F);
	COV_SW_SYNC: cover property (sw_sync && cfg_reg.fb_phase != 6'h00);
	COV_VCO_BLOCK: cover property (vco_half_en && cfg_reg.vco_pd);
endmodule

//--- sld_top_test.sv
`timescale 1ns/1ps
`include "sld_map.svh"
module sld_top_test;
	logic        core_clk = 1'h0;
	logic        rstn = 1'h0;
	logic [13:0] avs_address = 14'h0000;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ref_edge_en = 1'h0;
	logic        vco_half_en = 1'h0;
	logic        sync_in = 1'h0;
	logic        ref_div_pulse;
	logic        fb_div_pulse;
	logic        fb_div_level;
	logic        loop_zero_bypass;
	logic        vco_output_divider_pd;
	logic        feedback_divider_pd;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          ref_cnt = 0;
	int          ref_gap = 0;
	int          fb_cnt = 0;
	int          fb_gap = 0;
	int          fb_hi = 0;
	int          hi_gap = 0;
	int          fb_pulses = 0;
	int          d;
	int          f;
	int          p;
	int          tbl [4];

	sld_top dut (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .ref_edge_en, .vco_half_en, .sync_in,
		.ref_div_pulse, .fb_div_pulse, .fb_div_level, .loop_zero_bypass,
		.vco_output_divider_pd, .feedback_divider_pd);

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 40000) begin
			num_errors++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Divider period monitor: input steps between output pulses
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (ref_edge_en) ref_cnt++;
		if (ref_div_pulse) begin
			ref_gap = ref_cnt;
			ref_cnt = 0;
		end
		if (sync_in) begin
			fb_cnt = 0;
			fb_hi = 0;
		end
		if (vco_half_en) begin
			fb_cnt++;
			if (fb_div_level === 1'b1) fb_hi++;
		end
		if (fb_div_pulse) begin
			fb_gap = fb_cnt;
			hi_gap = fb_hi;
			fb_cnt = 0;
			fb_hi = 0;
			fb_pulses++;
		end
	end

	task automatic stop_test;
		if (num_errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask

	task automatic chk_count(input string n, input int e, input int g);
		comparisons++;
		if (g != e) begin
			$display("Error %s expected %0d seen %0d", n, e, g);
			num_errors++;
		end
	endtask

	function automatic int ref_period(input int code);
		return (code > 1) ? code : 1;
	endfunction

	function automatic int fb_half_steps(input int code);
		return 2 * (code + 1);
	endfunction

	// Avalon access: request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
		logic [31:0] q;
		bus(1'b1, idx, wd, q);
		// Register pins change at the accepting edge; look after they settle
		@(negedge core_clk);
	endtask

	task automatic rdc(input logic [11:0] idx, input logic [7:0] e, input string n);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk_data(n, {24'h00_0000, e}, q);
	endtask

	// Input steps two cycles apart; vco selects the feedback input
	task automatic steps(input bit vco, input int n);
		repeat (n) begin
			@(posedge core_clk);
			vco_half_en <= vco;
			ref_edge_en <= !vco;
			@(posedge core_clk);
			vco_half_en <= 1'b0;
			ref_edge_en <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
	endtask

	initial begin
		void'($urandom(32'hb647));
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		rdc(`SLD_IDX_BYPASS, 8'h00, "bypass");
		rdc(`SLD_IDX_PREDIV, 8'h00, "prediv");
		rdc(`SLD_IDX_FBDIV, 8'h00, "fbdiv");
		rdc(`SLD_IDX_FBPHASE, 8'h00, "phase");
		rdc(12'h300, 8'h00, "unmapped");
		wr(`SLD_IDX_BYPASS, 8'hff);
		rdc(`SLD_IDX_BYPASS, 8'h01, "bypass");
		chk_data("bypass_pin", 32'h0000_0001, {31'h0000_0000, loop_zero_bypass});
		wr(`SLD_IDX_BYPASS, 8'h00);
		chk_data("bypass_pin", 32'h0000_0000, {31'h0000_0000, loop_zero_bypass});
		tbl = '{0, 1, 31, 2};
		for (int i = 0; i < 5; i++) begin
			d = (i < 4) ? tbl[i] : $urandom_range(30, 3);
			wr(`SLD_IDX_PREDIV, {3'h7, d[4:0]});
			rdc(`SLD_IDX_PREDIV, {3'h0, d[4:0]}, "prediv");
			ref_gap = 0;
			steps(1'b0, 3 * ref_period(d));
			chk_count("ref_gap", ref_period(d), ref_gap);
		end
		tbl = '{0, 1, 255, 2};
		for (int i = 0; i < 5; i++) begin
			f = (i < 4) ? tbl[i] : $urandom_range(254, 3);
			wr(`SLD_IDX_FBDIV, f[7:0]);
			rdc(`SLD_IDX_FBDIV, f[7:0], "fbdiv");
			fb_gap = 0;
			steps(1'b1, 3 * fb_half_steps(f));
			chk_count("fb_gap", fb_half_steps(f), fb_gap);
			chk_count("fb_high", f + 1, hi_gap);
		end
		wr(`SLD_IDX_FBDIV, 8'h01);
		tbl = '{0, 1, 63, 2};
		for (int i = 0; i < 5; i++) begin
			p = (i < 4) ? tbl[i] : $urandom_range(62, 3);
			wr(`SLD_IDX_FBPHASE, {2'h2, p[5:0]});
			rdc(`SLD_IDX_FBPHASE, {2'h0, p[5:0]}, "phase");
			@(posedge core_clk);
			sync_in <= 1'b1;
			@(posedge core_clk);
			sync_in <= 1'b0;
			rdc(`SLD_IDX_STATUS, {7'h00, (p != 0)}, "status");
			fb_gap = 0;
			steps(1'b1, p + 4);
			chk_count("sync_gap", p + 4, fb_gap);
		end
		wr(`SLD_IDX_FBPHASE, 8'h40);
		chk_data("fb_pd_pin", 32'h0000_0001, {31'h0000_0000, feedback_divider_pd});
		fb_pulses = 0;
		steps(1'b1, 8);
		chk_count("fb_pd_pulses", 0, fb_pulses);
		chk_data("fb_pd_level", 32'h0000_0000, {31'h0000_0000, fb_div_level});
		wr(`SLD_IDX_FBPHASE, 8'h00);
		steps(1'b1, 8);
		chk_count("fb_run_pulses", 2, fb_pulses);
		wr(`SLD_IDX_AUX, 8'h03);
		rdc(`SLD_IDX_AUX, 8'h02, "aux");
		chk_data("vco_pd_pin", 32'h0000_0001, {31'h0000_0000, vco_output_divider_pd});
		fb_pulses = 0;
		steps(1'b1, 8);
		chk_count("vco_pd_pulses", 0, fb_pulses);
		wr(`SLD_IDX_AUX, 8'h00);
		chk_data("vco_pd_pin", 32'h0000_0000, {31'h0000_0000, vco_output_divider_pd});
		// Software sync with a phase of two half steps
		wr(`SLD_IDX_FBPHASE, 8'h02);
		wr(`SLD_IDX_AUX, 8'h01);
		fb_cnt = 0;
		fb_hi = 0;
		fb_gap = 0;
		steps(1'b1, 2 + fb_half_steps(1));
		chk_count("sw_sync_gap", 2 + fb_half_steps(1), fb_gap);
		chk_count("sw_sync_high", 2, hi_gap);
		stop_test();
	end
endmodule
